// >>> inc/flash_spi_regs.svh
/*
  Constants of the serial flash front end: instruction codes, status
  byte layout, array geometry and internal cycle times.
  Assumes a 40 MHz system clock; included by bare name.
*/
`ifndef FLASH_SPI_REGS_SVH
`define FLASH_SPI_REGS_SVH

// Instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_DATA 8'h03
`define OP_FAST_READ 8'h0b
`define OP_FAST_READ_DUAL 8'h3b
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_READ_ID 8'h90
`define OP_READ_ID_LONG 8'h9f

// Status byte bit positions and reset value
`define SR_BUSY 0
`define SR_WEL 1
`define SR_PROT_LO 2
`define SR_PROT_HI 4
`define SR_LOW_END 5
`define SR_LOCK 7
`define SR_RESET 8'h00

// Array geometry and serial clock limit
`define PAGE_BYTES 9'h100
`define SECTOR_PAGES 16
`define BLOCK_PAGES 256
`define BLOCK_LSB 16
`define SPI_CLK_MAX_MHZ 100

// Internal cycle times and their counts at the system clock
`define SYS_CLK_PERIOD_NS 25
`define WRSR_TIME_US 10
`define PROG_TIME_US 100
`define SECTOR_ERASE_US 1000
`define BLOCK_ERASE_US 5000
`define CHIP_ERASE_US 20000
`define WRSR_CYCLES (`WRSR_TIME_US * 1000 / `SYS_CLK_PERIOD_NS)
`define PROG_CYCLES (`PROG_TIME_US * 1000 / `SYS_CLK_PERIOD_NS)
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_US * 1000 / `SYS_CLK_PERIOD_NS)
`define BLOCK_ERASE_CYCLES (`BLOCK_ERASE_US * 1000 / `SYS_CLK_PERIOD_NS)
`define CHIP_ERASE_CYCLES (`CHIP_ERASE_US * 1000 / `SYS_CLK_PERIOD_NS)

`endif

// >>> inc/flash_spi_pkg.sv
/*
  Types shared by the serial flash front end modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_spi_pkg;
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_DUMMY, PH_WDATA, PH_OUT, PH_IGNORE
  } link_phase_t;
  typedef enum logic [1:0] {OUT_STATUS, OUT_MEM, OUT_ID} out_src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} engine_state_t;
  typedef enum logic [1:0] {ER_SECTOR, ER_BLOCK, ER_CHIP} erase_kind_t;
endpackage

// >>> src/flash_sync2.sv
/*
  Two flop level synchroniser.
  Assumes the input is a level that may change at any time.
*/
`timescale 1ns/1ps
module flash_sync2 (
  // Destination clock
  input wire logic clk,
  // Level in and synchronised level out
  input wire logic d,
  output logic q
);
  logic meta;

  // First flop feeds only the second one
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// >>> src/flash_protect.sv
/*
  Write protection check for one program or erase request.
  Assumes 64 KB blocks; density_sel picks 2, 4, 8 or 16 blocks.
*/
`timescale 1ns/1ps
`include "flash_spi_regs.svh"
module flash_protect (
  // Request
  input wire logic [23:0] addr,
  input wire flash_spi_pkg::erase_kind_t kind,
  // Protection state
  input wire logic [2:0] region_protect_bits,
  input wire logic protect_from_low_end,
  input wire logic [1:0] density_sel,
  // Result
  output logic hit
);
  import flash_spi_pkg::*;

  logic [4:0] nblk;
  logic [4:0] prot;
  logic [4:0] blk;

  // Block count of the fitted density and of the guarded region
  always_comb begin
    nblk = 5'h02 << density_sel;
    blk = {1'b0, addr[`BLOCK_LSB+3:`BLOCK_LSB]} & (nblk - 5'h01);
    if (region_protect_bits == 3'h0) begin
      prot = 5'h00;
    end else if (region_protect_bits == 3'h7) begin
      prot = nblk;
    end else begin
      prot = 5'h01 << (region_protect_bits - 3'h1);
      if (prot > nblk) begin
        prot = nblk;
      end
    end
  end

  // Guarded region grows from the top or the low end of the array
  always_comb begin
    if (prot == 5'h00) begin
      hit = 1'b0;
    end else if (kind == ER_CHIP) begin
      hit = 1'b1;
    end else if (protect_from_low_end) begin
      hit = blk < prot;
    end else begin
      hit = blk >= (nblk - prot);
    end
  end
endmodule

// >>> src/flash_spi_top.sv
/*
  Serial flash pin interface: instruction decode on the serial clock,
  program and erase engine on the system clock.
  Assumes an external array: asynchronous read port addressed from the
  link side, write and erase strobes from the system side.
*/
`timescale 1ns/1ps
`include "flash_spi_regs.svh"
module flash_spi_top #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h31, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h10, // Arbitrary value
  parameter logic [31:0] SECTOR_ERASE_CYC = `SECTOR_ERASE_CYCLES,
  parameter logic [31:0] BLOCK_ERASE_CYC = `BLOCK_ERASE_CYCLES,
  parameter logic [31:0] CHIP_ERASE_CYC = `CHIP_ERASE_CYCLES
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial link pins
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  output logic so_out,
  output logic so_oe,
  // Device size
  input wire logic [1:0] density_sel,
  // Array read port, link clock
  output logic [23:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // Array write port, system clock
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wr_data,
  output logic mem_wr,
  output logic mem_erase,
  output flash_spi_pkg::erase_kind_t mem_erase_kind,
  // Status bits
  output logic busy,
  output logic wel,
  output logic [2:0] region_protect_bits,
  output logic protect_from_low_end,
  output logic protect_lock_bit
);
  import flash_spi_pkg::*;

  localparam logic [31:0] WRSR_CYC = `WRSR_CYCLES;
  localparam logic [31:0] PROG_CYC = `PROG_CYCLES;

  // Link side state
  link_phase_t phase;
  out_src_t out_src;
  logic [5:0] cnt;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic load_now;
  logic out_on;
  logic dual;
  logic [1:0] id_sel;
  logic [8:0] pcount;
  logic armed;
  logic [7:0] out_sr;
  logic [7:0] src_byte;
  logic [7:0] pbuf [256];
  logic cmd_ready;
  logic [7:0] cmd_op;
  logic [23:0] cmd_addr;
  logic [7:0] cmd_sr;
  logic [8:0] cmd_count;
  logic [7:0] status_sys;
  logic [7:0] status_link;
  logic [7:0] next_shift;
  logic [23:0] next_addr;
  logic [8:0] next_pcount;
  logic out_kill;
  logic next_ready;

  // System side state
  engine_state_t state;
  logic [1:0] pins_s;
  logic cs_s;
  logic wp_s;
  logic cs_prev;
  logic cs_seen;
  logic cs_rise;
  logic [31:0] timer;
  logic [8:0] prog_idx;
  logic hit;
  erase_kind_t req_kind;

  assign next_shift = {shift_in[6:0], io_in};
  assign next_addr = {addr[22:0], io_in};
  assign next_pcount = (pcount == `PAGE_BYTES) ? pcount : pcount + 9'h001;

  // Pin levels into the system clock domain
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin_sync
      flash_sync2 u_sync (
        .clk(sys_clk),
        .d(gi == 0 ? cs_n : wp_n),
        .q(pins_s[gi])
      );
    end
    // Status levels into the link domain; refreshed only while clocked
    for (gi = 0; gi < 8; gi++) begin : g_status_sync
      flash_sync2 u_sync (
        .clk(spi_clk),
        .d(status_sys[gi]),
        .q(status_link[gi])
      );
    end
  endgenerate
  assign cs_s = pins_s[0];
  assign wp_s = pins_s[1];

  // Status byte as seen by the read status instruction
  always_comb begin
    status_sys = `SR_RESET;
    status_sys[`SR_BUSY] = busy;
    status_sys[`SR_WEL] = wel;
    status_sys[`SR_PROT_HI:`SR_PROT_LO] = region_protect_bits;
    status_sys[`SR_LOW_END] = protect_from_low_end;
    status_sys[`SR_LOCK] = protect_lock_bit;
  end

  // Frame start takes the power-up select history; it is a settled level
  always_ff @(negedge cs_n) begin
    armed <= cs_seen;
  end

  // Instruction decode on rising edges; select high clears it at once
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      phase <= PH_OPCODE;
      cnt <= 6'h00;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      load_now <= 1'b0;
      out_src <= OUT_STATUS;
      out_on <= 1'b0;
      dual <= 1'b0;
      id_sel <= 2'h0;
      pcount <= 9'h000;
      mem_rd_addr <= 24'h000000;
    end else if (hold_n) begin
      load_now <= 1'b0;
      cnt <= cnt + 6'h01;
      shift_in <= next_shift;
      case (phase)
        PH_OPCODE: begin
          if (cnt == 6'h07) begin
            cnt <= 6'h00;
            opcode <= next_shift;
            if (!armed) begin
              phase <= PH_IGNORE;
            end else begin
              case (next_shift)
                `OP_READ_STATUS: begin
                  phase <= PH_OUT;
                  out_on <= 1'b1;
                  load_now <= 1'b1;
                  out_src <= OUT_STATUS;
                end
                `OP_READ_ID_LONG: begin
                  phase <= PH_OUT;
                  out_on <= 1'b1;
                  load_now <= 1'b1;
                  out_src <= OUT_ID;
                  id_sel <= 2'h0;
                end
                `OP_WRITE_STATUS: phase <= PH_WDATA;
                `OP_READ_DATA, `OP_FAST_READ, `OP_FAST_READ_DUAL,
                `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE,
                `OP_READ_ID: phase <= PH_ADDR;
                default: phase <= PH_IGNORE;
              endcase
            end
          end
        end
        PH_ADDR: begin
          addr <= next_addr;
          if (cnt == 6'h17) begin
            cnt <= 6'h00;
            mem_rd_addr <= next_addr;
            case (opcode)
              `OP_READ_DATA: begin
                phase <= PH_OUT;
                out_on <= 1'b1;
                load_now <= 1'b1;
                out_src <= OUT_MEM;
              end
              `OP_FAST_READ, `OP_FAST_READ_DUAL: begin
                phase <= PH_DUMMY;
                dual <= (opcode == `OP_FAST_READ_DUAL);
              end
              `OP_PAGE_PROGRAM: phase <= PH_WDATA;
              `OP_READ_ID: begin
                phase <= PH_OUT;
                out_on <= 1'b1;
                load_now <= 1'b1;
                out_src <= OUT_ID;
                id_sel <= next_addr[0] ? 2'h2 : 2'h0;
              end
              default: phase <= PH_IGNORE;
            endcase
          end
        end
        PH_DUMMY: begin
          if (cnt == 6'h07) begin
            cnt <= 6'h00;
            phase <= PH_OUT;
            out_on <= 1'b1;
            load_now <= 1'b1;
            out_src <= OUT_MEM;
          end
        end
        PH_WDATA: begin
          if (cnt == 6'h07) begin
            cnt <= 6'h00;
            pcount <= next_pcount;
            if (opcode == `OP_WRITE_STATUS) begin
              phase <= PH_IGNORE;
            end
          end
        end
        PH_OUT: begin
          // Dual read moves two bits per clock, so four clocks a byte
          if (cnt == (dual ? 6'h03 : 6'h07)) begin
            cnt <= 6'h00;
            load_now <= 1'b1;
            if (out_src == OUT_MEM) begin
              mem_rd_addr <= mem_rd_addr + 24'h000001;
            end
            if (opcode == `OP_READ_ID_LONG) begin
              id_sel <= (id_sel == 2'h2) ? 2'h0 : id_sel + 2'h1;
            end else if (out_src == OUT_ID) begin
              id_sel <= id_sel ^ 2'h2;
            end
          end
        end
        default: cnt <= 6'h00;
      endcase
    end
  end

  // A command is complete only when the last bit ends a byte
  always_comb begin
    next_ready = 1'b0;
    case (phase)
      PH_OPCODE: next_ready = armed && (cnt == 6'h07) &&
        (next_shift == `OP_WRITE_ENABLE || next_shift == `OP_WRITE_DISABLE ||
         next_shift == `OP_CHIP_ERASE_A || next_shift == `OP_CHIP_ERASE_B);
      PH_ADDR: next_ready = (cnt == 6'h17) &&
        (opcode == `OP_SECTOR_ERASE || opcode == `OP_BLOCK_ERASE);
      PH_WDATA: next_ready = (cnt == 6'h07);
      default: next_ready = 1'b0;
    endcase
  end

  // Command hand-off; held after select rises for the engine to read
  always_ff @(posedge spi_clk) begin
    if (!cs_n && hold_n) begin
      cmd_ready <= next_ready;
      cmd_op <= (phase == PH_OPCODE) ? next_shift : opcode;
      if (phase == PH_ADDR) begin
        cmd_addr <= next_addr;
      end
      if (phase == PH_WDATA && cnt == 6'h07) begin
        cmd_sr <= next_shift;
        cmd_count <= next_pcount;
      end
    end
  end

  // Page buffer; bytes after the 256th all land on the first byte's slot
  always_ff @(posedge spi_clk) begin
    if (!cs_n && hold_n && phase == PH_WDATA && cnt == 6'h07 &&
        opcode == `OP_PAGE_PROGRAM) begin
      pbuf[addr[7:0] + pcount[7:0]] <= next_shift;
    end
  end

  // Byte chosen for the next load; array read is asynchronous
  always_comb begin
    case (out_src)
      OUT_MEM: src_byte = mem_rd_data;
      OUT_ID: begin
        case (id_sel)
          2'h0: src_byte = MAKER_ID;
          2'h1: src_byte = TYPE_ID;
          default: src_byte = DEVICE_ID + {6'h00, density_sel};
        endcase
      end
      default: src_byte = status_link;
    endcase
  end

  // Output data changes on falling edges, state kept over a pause
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      out_sr <= 8'h00;
      so_out <= 1'b0;
      io_out <= 1'b0;
    end else if (hold_n) begin
      if (load_now) begin
        so_out <= src_byte[7];
        io_out <= src_byte[6];
        out_sr <= dual ? {src_byte[5:0], 2'h0} : {src_byte[6:0], 1'b0};
      end else begin
        so_out <= out_sr[7];
        io_out <= out_sr[6];
        out_sr <= dual ? {out_sr[5:0], 2'h0} : {out_sr[6:0], 1'b0};
      end
    end
  end

  // Enables drop at once on deselect, or on pause with the clock low
  assign out_kill = cs_n | (~hold_n & ~spi_clk);
  always_ff @(negedge spi_clk or posedge out_kill) begin
    if (out_kill) begin
      so_oe <= 1'b0;
      io_oe <= 1'b0;
    end else begin
      so_oe <= out_on & hold_n;
      io_oe <= out_on & dual & hold_n;
    end
  end

  // Select edges seen by the engine
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs_prev <= 1'b1;
      cs_seen <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      if (cs_s) begin
        cs_seen <= 1'b1;
      end
    end
  end
  assign cs_rise = cs_s & ~cs_prev;

  // Guard check for the pending command
  always_comb begin
    case (cmd_op)
      `OP_BLOCK_ERASE: req_kind = ER_BLOCK;
      `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: req_kind = ER_CHIP;
      default: req_kind = ER_SECTOR;
    endcase
  end

  flash_protect u_protect (
    .addr(cmd_addr),
    .kind(req_kind),
    .region_protect_bits(region_protect_bits),
    .protect_from_low_end(protect_from_low_end),
    .density_sel(density_sel),
    .hit(hit)
  );

  // Program and erase engine; runs on whatever select does meanwhile
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      wel <= 1'b0;
      region_protect_bits <= 3'h0;
      protect_from_low_end <= 1'b0;
      protect_lock_bit <= 1'b0;
      timer <= 32'h00000000;
      prog_idx <= 9'h000;
      mem_addr <= 24'h000000;
      mem_wr_data <= 8'h00;
      mem_wr <= 1'b0;
      mem_erase <= 1'b0;
      mem_erase_kind <= ER_SECTOR;
    end else begin
      mem_wr <= 1'b0;
      mem_erase <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cs_rise && cs_seen && cmd_ready) begin
            case (cmd_op)
              `OP_WRITE_ENABLE: wel <= 1'b1;
              `OP_WRITE_DISABLE: wel <= 1'b0;
              `OP_WRITE_STATUS: begin
                if (wel && !(protect_lock_bit && !wp_s)) begin
                  region_protect_bits <= cmd_sr[`SR_PROT_HI:`SR_PROT_LO];
                  protect_from_low_end <= cmd_sr[`SR_LOW_END];
                  protect_lock_bit <= cmd_sr[`SR_LOCK];
                  busy <= 1'b1;
                  timer <= WRSR_CYC;
                  state <= ST_WAIT;
                end
              end
              `OP_PAGE_PROGRAM: begin
                if (wel && !hit) begin
                  busy <= 1'b1;
                  prog_idx <= 9'h000;
                  state <= ST_PROG;
                end
              end
              default: begin
                if (wel && !hit) begin
                  mem_erase <= 1'b1;
                  mem_erase_kind <= req_kind;
                  mem_addr <= cmd_addr;
                  busy <= 1'b1;
                  state <= ST_WAIT;
                  case (req_kind)
                    ER_BLOCK: timer <= BLOCK_ERASE_CYC;
                    ER_CHIP: timer <= CHIP_ERASE_CYC;
                    default: timer <= SECTOR_ERASE_CYC;
                  endcase
                end
              end
            endcase
          end
        end
        ST_PROG: begin
          // One byte per cycle, offset wraps inside the page
          mem_wr <= 1'b1;
          mem_addr <= {cmd_addr[23:8], cmd_addr[7:0] + prog_idx[7:0]};
          mem_wr_data <= pbuf[cmd_addr[7:0] + prog_idx[7:0]];
          prog_idx <= prog_idx + 9'h001;
          if (prog_idx + 9'h001 >= cmd_count) begin
            timer <= PROG_CYC;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer == 32'h00000000) begin
            busy <= 1'b0;
            wel <= 1'b0;
            state <= ST_IDLE;
          end else begin
            timer <= timer - 32'h00000001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/flash_spi_chk.sv
/*
  Pin assertions for the serial flash front end.
  Assumes it is bound into every flash_spi_top; sees only its ports.
*/
`timescale 1ns/1ps
module flash_spi_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link pins
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_oe,
  input wire logic io_oe,
  // Engine and status
  input wire logic mem_wr,
  input wire logic mem_erase,
  input wire logic busy,
  input wire logic wel,
  input wire logic [2:0] region_protect_bits,
  input wire logic protect_from_low_end,
  input wire logic protect_lock_bit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Six cycles give the guard pin sync time to settle
  sequence locked_s;
    (protect_lock_bit && !wp_n) [*6];
  endsequence
  // Paused with the clock parked low long enough to have floated
  sequence paused_s;
    (!hold_n && !cs_n && !spi_clk) [*3];
  endsequence
  oe_deselect_a: assert property ((so_oe || io_oe) |-> !cs_n)
    else $error("output driven while deselected");
  dual_pair_a: assert property (io_oe |-> so_oe)
    else $error("io driven without data output");
  pause_float_a: assert property (paused_s |-> !so_oe && !io_oe)
    else $error("output driven during pause");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("internal cycle cut short");
  write_busy_a: assert property (mem_wr |-> busy && wel)
    else $error("byte programmed outside a program cycle");
  erase_pulse_a: assert property (
    mem_erase |-> wel ##1 (!mem_erase && busy))
    else $error("erase strobe malformed");
  lock_guard_a: assert property (
    locked_s |-> $stable(region_protect_bits) &&
      $stable(protect_from_low_end))
    else $error("locked protect bits changed");
  protect_wel_a: assert property (
    $changed(region_protect_bits) |-> $past(wel))
    else $error("protect bits changed without write enable");
endmodule

bind flash_spi_top flash_spi_chk u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n),
  .wp_n(wp_n), .so_oe(so_oe), .io_oe(io_oe), .mem_wr(mem_wr),
  .mem_erase(mem_erase), .busy(busy), .wel(wel),
  .region_protect_bits(region_protect_bits),
  .protect_from_low_end(protect_from_low_end),
  .protect_lock_bit(protect_lock_bit));

// >>> verif/spi_host_model.sv
/*
  Behavioural mode 0 SPI host facing the flash front end.
  Assumes the bench calls frame() one at a time; clock parks low.
*/
`timescale 1ns/1ps
module spi_host_model (
  // Alignment only
  input wire logic sys_clk,
  // Pins toward the device
  output logic spi_clk,
  output logic cs_n,
  output logic hold_n,
  output logic io_in,
  // Pins from the device
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic so_out,
  input wire logic so_oe
);
  logic h_bit;
  logic h_en;
  logic so_lvl;
  // Released lines show the inverse so a stale bit never matches
  assign io_in = io_oe ? io_out : (h_en ? h_bit : ~h_bit);
  assign so_lvl = so_oe ? so_out : ~so_out;
  // Idle: deselected, clock low, not paused
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    h_bit = 1'b0;
    h_en = 1'b1;
  end
  // One 30 ns clock: drive while low, sample at the rise
  task automatic tick(input logic b, input bit dual, inout logic [31:0] rx);
    h_bit = b;
    h_en = !dual;
    #7.5 spi_clk = 1'b1;
    rx = dual ? {rx[29:0], so_lvl, io_in} : {rx[30:0], so_lvl};
    #15 spi_clk = 1'b0;
    #7.5;
  endtask
  // Whole frame; hold_at pauses before that address bit
  task automatic frame(input logic [7:0] op, input logic [23:0] adr,
    input bit has_a, input logic [15:0] wd, input int nwd, input int ndum,
    input int nrx, input bit dual, input int hold_at,
    output logic [31:0] rx);
    logic [31:0] junk;
    junk = '0;
    rx = '0;
    @(posedge sys_clk);
    #4 cs_n = 1'b0;
    #7.5;
    for (int i = 7; i >= 0; i--) tick(op[i], 1'b0, rx);
    for (int i = 23; i >= 0 && has_a; i--) begin
      if (i == hold_at) begin
        hold_n = 1'b0;
        repeat (3) tick(~adr[i], 1'b0, junk);
        #100 hold_n = 1'b1;
      end
      tick(adr[i], 1'b0, rx);
    end
    for (int i = nwd - 1; i >= 0; i--) tick(wd[i], 1'b0, rx);
    repeat (ndum) tick(1'b0, 1'b0, rx);
    rx = '0;
    repeat (nrx) tick(1'b0, dual, rx);
    h_en = 1'b1;
    cs_n = 1'b1;
    #200;
  endtask
endmodule

// >>> verif/serial_flash_spi_pin_interface_bench.sv
/*
  Self-checking bench for the serial flash front end.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "flash_spi_regs.svh"
module serial_flash_spi_pin_interface_bench;
  import flash_spi_pkg::*;
  logic sys_clk, reset_n, spi_clk, cs_n, hold_n, wp_n, io_in;
  logic io_out, io_oe, so_out, so_oe, mem_wr, mem_erase, busy, wel;
  logic protect_from_low_end, protect_lock_bit;
  logic [1:0] density_sel;
  logic [2:0] region_protect_bits;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic [23:0] mem_rd_addr, mem_addr;
  erase_kind_t mem_erase_kind;
  logic [31:0] rx;
  logic [31:0] wq[$];
  logic [1:0] eq[$];
  int n_errors, n_compared;
  // Array stand-in: content depends on two address bytes
  function automatic logic [7:0] fm(input logic [23:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  assign mem_rd_data = fm(mem_rd_addr);
  flash_spi_top #(.MAKER_ID(8'hc4), .TYPE_ID(8'h71),
    .SECTOR_ERASE_CYC(20), .BLOCK_ERASE_CYC(30), .CHIP_ERASE_CYC(40))
    u_flash_spi_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .so_out(so_out),
    .so_oe(so_oe), .density_sel(density_sel), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_wr(mem_wr), .mem_erase(mem_erase),
    .mem_erase_kind(mem_erase_kind), .busy(busy), .wel(wel),
    .region_protect_bits(region_protect_bits),
    .protect_from_low_end(protect_from_low_end),
    .protect_lock_bit(protect_lock_bit));
  spi_host_model u_spi_host_model (.sys_clk(sys_clk), .spi_clk(spi_clk),
    .cs_n(cs_n), .hold_n(hold_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .so_out(so_out), .so_oe(so_oe));
  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Record every array strobe for later comparison
  always @(posedge sys_clk) begin
    if (mem_wr === 1'b1) wq.push_back({mem_addr, mem_wr_data});
    if (mem_erase === 1'b1) eq.push_back(mem_erase_kind);
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait for the engine to go idle
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 6000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 6000) begin
      chk("busy", busy, 1'b0);
      end_sim();
    end
  endtask
  task automatic op(input logic [7:0] code, input logic [15:0] wd = 0,
    input int nwd = 0);
    u_spi_host_model.frame(code, 24'h0, 0, wd, nwd, 0, 0, 0, -1, rx);
  endtask
  task automatic t_id();
    u_spi_host_model.frame(`OP_READ_ID_LONG, 0, 0, 0, 0, 0, 24, 0, -1, rx);
    chk("id", rx[23:8], 16'hc471);
    chk("so_oe idle", so_oe, 1'b0);
    $display("id test done");
  endtask
  task automatic t_read();
    u_spi_host_model.frame(`OP_READ_DATA, 24'h1fe, 1, 0, 0, 0, 24, 0, -1,
      rx);
    chk("read", rx[23:0], {fm(24'h1fe), fm(24'h1ff), fm(24'h200)});
    $display("read test done");
  endtask
  // Dual fast read, paused with clock toggling mid address
  task automatic t_dual();
    u_spi_host_model.frame(`OP_FAST_READ_DUAL, 24'ha10, 1, 0, 0, 8, 8, 1, 5,
      rx);
    chk("dual", rx[15:0], {fm(24'ha10), fm(24'ha11)});
    $display("dual test done");
  endtask
  // Enable followed by four stray bits must not act; aborted read leaves link idle
  task automatic t_abort();
    op(`OP_WRITE_ENABLE, 16'h5, 4);
    chk("wel cut", wel, 1'b0);
    op(`OP_READ_DATA);
    u_spi_host_model.frame(`OP_READ_STATUS, 0, 0, 0, 0, 0, 16, 0, -1, rx);
    chk("status", rx[7:0], 8'h00);
    $display("abort test done");
  endtask
  task automatic t_prog();
    wq.delete();
    op(`OP_WRITE_ENABLE);
    chk("wel", wel, 1'b1);
    u_spi_host_model.frame(`OP_PAGE_PROGRAM, 24'h1ff, 1, 16'ha1b2, 16, 0, 0,
      0, -1, rx);
    wait_idle();
    chk("writes", wq.size(), 2);
    chk("byte0", wq[0], 32'h0001ffa1);
    chk("byte1", wq[1], 32'h000100b2);
    chk("wel end", wel, 1'b0);
    $display("program test done");
  endtask
  task automatic t_erase();
    logic [7:0] ops [4];
    ops = '{`OP_SECTOR_ERASE, `OP_BLOCK_ERASE, `OP_CHIP_ERASE_A,
      `OP_CHIP_ERASE_B};
    for (int i = 0; i < 4; i++) begin
      eq.delete();
      op(`OP_WRITE_ENABLE);
      u_spi_host_model.frame(ops[i], 24'h13000, i < 2, 0, 0, 0, 0, 0, -1,
        rx);
      wait_idle();
      chk("erase count", eq.size(), 1);
      chk("erase kind", eq[0], (i < 2) ? i : 2);
    end
    $display("erase test done");
  endtask
  // Lock with guard low freezes bits; guarded top block refuses program
  task automatic t_prot();
    op(`OP_WRITE_ENABLE);
    op(`OP_WRITE_STATUS, 16'h84, 8);
    wait_idle();
    chk("bp set", {protect_lock_bit, region_protect_bits}, 4'h9);
    @(posedge sys_clk) wp_n <= 1'b0;
    op(`OP_WRITE_ENABLE);
    op(`OP_WRITE_STATUS, 16'h00, 8);
    wait_idle();
    chk("bp locked", region_protect_bits, 3'h1);
    wq.delete();
    op(`OP_WRITE_ENABLE);
    u_spi_host_model.frame(`OP_PAGE_PROGRAM, 24'h10000, 1, 16'h5a, 8, 0, 0,
      0, -1, rx);
    wait_idle();
    chk("guarded", wq.size(), 0);
    // Four blocks: the same guard now covers only block 3
    @(posedge sys_clk) density_sel <= 2'h1;
    op(`OP_WRITE_ENABLE);
    u_spi_host_model.frame(`OP_PAGE_PROGRAM, 24'h10000, 1, 16'h5a, 8, 0, 0,
      0, -1, rx);
    wait_idle();
    chk("four blocks", wq.size(), 1);
    @(posedge sys_clk) wp_n <= 1'b1;
    op(`OP_WRITE_ENABLE);
    op(`OP_WRITE_STATUS, 16'h00, 8);
    wait_idle();
    chk("bp clear", {protect_lock_bit, region_protect_bits}, 4'h0);
    $display("protect test done");
  endtask
  // Reset, then every scenario in turn
  initial begin
    n_errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    wp_n = 1'b1;
    density_sel = 2'h0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_id();
    t_read();
    t_dual();
    t_abort();
    t_prog();
    t_erase();
    t_prot();
    end_sim();
  end
endmodule
